// ===== rtl/scb_flag_bank.sv
// Bank of sticky flags, each set by a hardware event and cleared by a request.
// Assumes set and clear pulses on ref_clk; set wins when both arrive together.
`timescale 1ns/100ps
module scb_flag_bank import scb_pkg::*; #(
    parameter int WIDTH = 11
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flag_q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            logic flag_d;
            assign flag_d = set_in[i] | (flag_q[i] & ~clr_in[i]);
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    flag_q[i] <= 1'b0;
                end else begin
                    flag_q[i] <= flag_d;
                end
            end
        end
    endgenerate
endmodule

// ===== rtl/scb_map.svh
// Constants of the sense condition branch unit: codes, bit positions, offsets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
`define SCB_CLK_PERIOD_NS 10
`define SCB_EXEC_TIME_NS 12000
`define SCB_EXEC_CYCLES (`SCB_EXEC_TIME_NS / `SCB_CLK_PERIOD_NS)
`define SCB_OP_BSN 6'h2A
`define SCB_AUX_ROVF 6'h0B
`define SCB_AUX_MPAR 6'h0D
`define SCB_AUX_APAR 6'h0E
`define SCB_AUX_TPAR 6'h0F
`define SCB_AUX_SW1 6'h11
`define SCB_AUX_SW4 6'h14
`define SCB_AUX_SPAR 6'h15
`define SCB_AUX_SWO 6'h18
`define SCB_AUX_AL1 6'h21
`define SCB_AUX_AL2 6'h22
`define SCB_AUX_IC1 6'h23
`define SCB_AUX_IC4 6'h26
`define SCB_OPR_IC1 6'h08
`define SCB_OPR_IC4 6'h0B
`define SCB_NFLAGS 11
`define SCB_F_ROVF 0
`define SCB_F_MPAR 1
`define SCB_F_APAR 2
`define SCB_F_TPAR 3
`define SCB_F_SPAR 4
`define SCB_F_AL1 5
`define SCB_F_AL2 6
`define SCB_F_IC1 7
`define SCB_ADDR_FLAGS 8'h00
`define SCB_ADDR_ISTAT 8'h04
`define SCB_ADDR_IMASK 8'h08
`define SCB_ADDR_INPUTS 8'h0C
`define SCB_IMASK_RST 11'h000
`endif

// ===== rtl/scb_pkg.sv
// Types shared by the sense condition branch unit.
// Assumes scb_map.svh is on the include path.
`include "scb_map.svh"
package scb_pkg;
    typedef struct packed {
        logic [5:0] opcode;
        logic [5:0] aux;
    } scb_instr_s;
    typedef struct packed {
        logic taken;
        logic [16:0] pc;
        logic [16:0] right_a;
    } scb_branch_s;
    typedef enum logic [0:0] {
        SCB_IDLE = 1'b0,
        SCB_EXEC = 1'b1
    } scb_state_e;
    typedef logic [`SCB_NFLAGS-1:0] scb_flags_t;
endpackage

// ===== rtl/scb_sync.sv
// Two-stage synchroniser bank for levels arriving from pins.
// Assumes every input is asynchronous to ref_clk; only the second stage is read outside.
`timescale 1ns/100ps
module scb_sync import scb_pkg::*; #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== rtl/scb_unit.sv
// Sense condition branch unit: sticky error and alarm flags, branch-on-sense execution,
// intercommunication with the duplex partner, and an APB register window with interrupt.
// Assumes sequencer strobes on ref_clk; console and partner signals are asynchronous pins.
//
// Functional notes
// - Sense code 13 branches on right overflow flag and clears it.
// - Right overflow sets its flag only when the overflow enable bit is one.
// - Auto overflow branch needs branch bit and console overflow switch; else only flag.
// - Sense code 15 branches on memory parity flag and clears it.
// - Addressable drum parity sets its flag; code 16 branches and clears it.
// - Tape parity sets its flag; code 17 branches and clears it.
// - Codes 21 to 24 test sense switches 1 to 4, leaving them untouched.
// - Status drum parity sets its flag; code 25 branches and clears it.
// - Code 30 branches once duplex switchover has completed.
// - Inactivity, memory or addressable drum parity sets alarm 1; code 41 branches, clears.
// - Tape or status drum parity sets alarm 2; code 42 branches and clears.
// - Operate codes 10 to 13 set intercommunication flags 1 to 4 in the partner.
// - Codes 43 to 46 test intercommunication flags, clearing only the selected one.
// - Taken branch: program counter to right A, address register to program counter.
// - Branch on sense has opcode octal 52; bits L10 to L15 are the sense code.
// - Execution takes 12 microseconds and the address is never index-modified.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`include "scb_map.svh"
module scb_unit import scb_pkg::*; #(
    parameter int EXEC_CYCLES = `SCB_EXEC_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic branch_on_sense_start,
    input wire scb_instr_s instr,
    input wire logic [16:0] pc_in,
    input wire logic [16:0] addr_in,
    output logic busy,
    output logic branch_done,
    output scb_branch_s branch_out,
    input wire logic operate_command_evt,
    input wire logic [5:0] operate_aux,
    input wire logic right_ovf_evt,
    input wire logic overflow_enable_bit,
    input wire logic right_overflow_branch_bit,
    output logic ovf_auto_branch,
    input wire logic mem_parity_evt,
    input wire logic adrum_parity_evt,
    input wire logic tape_parity_evt,
    input wire logic sdrum_parity_evt,
    input wire logic inactivity_evt,
    input wire logic console_ovf_switch,
    input wire logic [3:0] sense_switch,
    input wire logic switchover_done,
    input wire logic [3:0] partner_notify_tgl,
    output logic [3:0] notify_partner_tgl,
    output logic irq
);
    // Pin inputs: console overflow switch, four sense switches, switchover, partner toggles.
    logic [9:0] pins_s;
    scb_sync #(.WIDTH(10)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({partner_notify_tgl, switchover_done, sense_switch, console_ovf_switch}),
        .sync_out(pins_s)
    );
    wire logic con_ovf_s = pins_s[0];
    wire logic [3:0] sw_s = pins_s[4:1];
    wire logic swo_s = pins_s[5];
    wire logic [3:0] ptgl_s = pins_s[9:6];

    // The partner signals each notify as a toggle, so no pulse is lost across the pins.
    logic [3:0] ptgl_q;
    wire logic [3:0] ic_set = ptgl_s ^ ptgl_q;

    // Flag set events.
    wire logic rovf_set = right_ovf_evt & overflow_enable_bit;
    wire logic al1_set = inactivity_evt | mem_parity_evt | adrum_parity_evt;
    wire logic al2_set = tape_parity_evt | sdrum_parity_evt;
    wire scb_flags_t flag_set = {ic_set, al2_set, al1_set, sdrum_parity_evt,
        tape_parity_evt, adrum_parity_evt, mem_parity_evt, rovf_set};
    scb_flags_t flag_q;
    scb_flags_t flag_clr;
    scb_flag_bank #(.WIDTH(`SCB_NFLAGS)) u_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flag_q(flag_q)
    );

    // Sense code decode on the latched auxiliary bits.
    scb_state_e state_q;
    logic [10:0] cnt_q;
    logic [5:0] aux_q;
    logic [16:0] pc_q;
    logic [16:0] addr_q;
    wire logic [5:0] ic_off = aux_q - `SCB_AUX_IC1;
    wire logic [5:0] sw_off = aux_q - `SCB_AUX_SW1;
    wire logic is_ic = (aux_q >= `SCB_AUX_IC1) && (aux_q <= `SCB_AUX_IC4);
    wire logic is_sw = (aux_q >= `SCB_AUX_SW1) && (aux_q <= `SCB_AUX_SW4);
    wire scb_flags_t sel_flag = {
        {3'h0, is_ic} << ic_off[1:0],
        aux_q == `SCB_AUX_AL2,
        aux_q == `SCB_AUX_AL1,
        aux_q == `SCB_AUX_SPAR,
        aux_q == `SCB_AUX_TPAR,
        aux_q == `SCB_AUX_APAR,
        aux_q == `SCB_AUX_MPAR,
        aux_q == `SCB_AUX_ROVF};
    wire logic [3:0] sel_sw = {3'h0, is_sw} << sw_off[1:0];
    wire logic sel_swo = aux_q == `SCB_AUX_SWO;
    wire logic cond_on = (|(flag_q & sel_flag)) | (|(sw_s & sel_sw)) | (sel_swo & swo_s);
    wire logic assigned = (|sel_flag) | (|sel_sw) | sel_swo;
    wire logic exec_end = (state_q == SCB_EXEC) && (cnt_q == 11'h000);
    // Only the selected flag is cleared; an unassigned code selects none.
    assign flag_clr = (exec_end && cond_on) ? sel_flag : '0;
    wire logic accept = branch_on_sense_start && (state_q == SCB_IDLE)
        && (instr.opcode == `SCB_OP_BSN);

    // Execution: the condition is strobed at the end of the fixed execution time, so
    // an event arriving during the instruction still counts.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= SCB_IDLE;
            cnt_q <= 11'h000;
            aux_q <= 6'h00;
            pc_q <= 17'h00000;
            addr_q <= 17'h00000;
        end else if (accept) begin
            state_q <= SCB_EXEC;
            cnt_q <= 11'(EXEC_CYCLES - 2);
            aux_q <= instr.aux;
            pc_q <= pc_in;
            addr_q <= addr_in; // Taken as given: no index modification.
        end else if (exec_end) begin
            state_q <= SCB_IDLE;
        end else if (state_q == SCB_EXEC) begin
            cnt_q <= cnt_q - 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            branch_done <= 1'b0;
            branch_out <= '0;
        end else begin
            busy <= accept | ((state_q == SCB_EXEC) & ~exec_end);
            branch_done <= exec_end;
            if (exec_end) begin
                branch_out.taken <= cond_on & assigned;
                branch_out.pc <= cond_on ? addr_q : pc_q;
                branch_out.right_a <= cond_on ? pc_q : 17'h00000;
            end
        end
    end

    // Overflow alarm branch and partner notification toggles.
    wire logic is_opr_ic = operate_command_evt && (operate_aux >= `SCB_OPR_IC1)
        && (operate_aux <= `SCB_OPR_IC4);
    wire logic [5:0] opr_off = operate_aux - `SCB_OPR_IC1;
    wire logic [3:0] notify_flip = {3'h0, is_opr_ic} << opr_off[1:0];
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovf_auto_branch <= 1'b0;
            notify_partner_tgl <= 4'h0;
            ptgl_q <= 4'h0;
        end else begin
            ovf_auto_branch <= rovf_set & right_overflow_branch_bit & con_ovf_s;
            notify_partner_tgl <= notify_partner_tgl ^ notify_flip;
            ptgl_q <= ptgl_s;
        end
    end

    // APB slave with one wait state; unmapped addresses answer with pslverr.
    logic [`SCB_NFLAGS-1:0] istat_q;
    logic [`SCB_NFLAGS-1:0] imask_q;
    wire logic apb_acc = psel & penable & ~pready;
    wire logic hit_flags = paddr == `SCB_ADDR_FLAGS;
    wire logic hit_istat = paddr == `SCB_ADDR_ISTAT;
    wire logic hit_imask = paddr == `SCB_ADDR_IMASK;
    wire logic hit_inputs = paddr == `SCB_ADDR_INPUTS;
    wire logic hit_any = hit_flags | hit_istat | hit_imask | hit_inputs;
    wire logic [31:0] rd_mux =
        hit_flags ? {21'h000000, flag_q} :
        hit_istat ? {21'h000000, istat_q} :
        hit_imask ? {21'h000000, imask_q} :
        hit_inputs ? {26'h0000000, swo_s, sw_s, con_ovf_s} : 32'h00000000;
    wire logic istat_rd = apb_acc & ~pwrite & hit_istat;
    // Status bits record each flag set event; a read clears them but a new event wins.
    wire logic [`SCB_NFLAGS-1:0] istat_d = flag_set | (istat_rd ? '0 : istat_q);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            imask_q <= `SCB_IMASK_RST;
            istat_q <= '0;
            irq <= 1'b0;
        end else begin
            pready <= apb_acc;
            pslverr <= apb_acc & ~hit_any;
            prdata <= (apb_acc & ~pwrite) ? rd_mux : 32'h00000000;
            if (apb_acc & pwrite & hit_imask) begin
                imask_q <= pwdata[`SCB_NFLAGS-1:0];
            end
            istat_q <= istat_d;
            irq <= |(istat_d & imask_q);
        end
    end

    // Helper counter of cycles since an accepted instruction, read only by assertions.
    logic [11:0] chk_cyc_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chk_cyc_q <= 12'h000;
        end else if (accept) begin
            chk_cyc_q <= 12'h001;
        end else if (state_q == SCB_EXEC) begin
            chk_cyc_q <= chk_cyc_q + 12'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_rovf_gate: assert property ($rose(flag_q[`SCB_F_ROVF]) |->
        $past(right_ovf_evt) && $past(overflow_enable_bit))
        else $error("right overflow flag set without enable bit");
    chk_ovf_alarm: assert property (ovf_auto_branch |->
        $past(right_overflow_branch_bit) && $past(con_ovf_s) && $past(rovf_set))
        else $error("overflow auto branch without its conditions");
    chk_exec_time: assert property (branch_done |->
        chk_cyc_q == 12'(EXEC_CYCLES))
        else $error("branch on sense did not take the execution time");
    chk_branch_pc: assert property (branch_done && branch_out.taken |->
        branch_out.pc == addr_q && branch_out.right_a == pc_q)
        else $error("taken branch moved the wrong addresses");
    chk_flag_clear: assert property ((|flag_clr) |=>
        ((flag_q & $past(flag_clr) & ~$past(flag_set)) == '0))
        else $error("sensed flag not cleared");
    chk_set_wins: assert property (((flag_set & flag_clr) != '0) |=>
        ((flag_q & $past(flag_set & flag_clr)) == $past(flag_set & flag_clr)))
        else $error("flag event lost against a clear");
    chk_unassigned_quiet: assert property (exec_end && !assigned |=>
        !branch_out.taken && flag_q == $past(flag_q | flag_set))
        else $error("unassigned code changed state");
    chk_bsn_only: assert property (branch_on_sense_start && state_q == SCB_IDLE &&
        instr.opcode != `SCB_OP_BSN |=> state_q == SCB_IDLE)
        else $error("non branch on sense instruction was executed");
    chk_notify_toggle: assert property (is_opr_ic |=>
        $countones(notify_partner_tgl ^ $past(notify_partner_tgl)) == 1)
        else $error("operate command did not notify the partner");
    chk_switch_taken: assert property (exec_end && is_sw |=>
        branch_out.taken == $past(|(sw_s & sel_sw)) && flag_q == $past(flag_q | flag_set))
        else $error("sense switch test wrong");
    chk_swo_taken: assert property (exec_end && sel_swo |=>
        branch_out.taken == $past(swo_s))
        else $error("switchover test wrong");
    chk_alarm1_set: assert property ((inactivity_evt || mem_parity_evt ||
        adrum_parity_evt) |=> flag_q[`SCB_F_AL1])
        else $error("alarm 1 condition did not set its flag");
    chk_alarm2_set: assert property ((tape_parity_evt || sdrum_parity_evt) |=>
        flag_q[`SCB_F_AL2])
        else $error("alarm 2 condition did not set its flag");
    chk_not_taken: assert property (branch_done && !branch_out.taken |->
        branch_out.pc == pc_q && branch_out.right_a == 17'h00000)
        else $error("branch not taken but addresses moved");
    chk_busy_span: assert property (accept |=> busy)
        else $error("accepted instruction did not raise busy");

    cov_taken: cover property (branch_done && branch_out.taken);
    cov_auto_branch: cover property (ovf_auto_branch);
    cov_not_taken: cover property (branch_done && !branch_out.taken);
    cov_irq: cover property ($rose(irq));
    cov_partner: cover property (|ic_set);
endmodule

// ===== sim/scb_partner.sv
// Duplex partner model: raises intercom notifications and counts those it receives.
// Assumes the unit toggles one notify pin once per valid operate command.
`timescale 1ns/100ps
module scb_partner (
    input wire logic ref_clk,
    input wire logic [3:0] notify_in,
    output logic [3:0] tgl_out,
    output logic [7:0] rx_cnt
);
    logic [3:0] prev_q = 4'h0;
    initial begin
        tgl_out = 4'h0;
        rx_cnt = 8'h00;
    end
    // Every edge on a notify pin is one flag set request, so edges are counted.
    always @(posedge ref_clk) begin
        rx_cnt <= rx_cnt + 8'($countones(notify_in ^ prev_q));
        prev_q <= notify_in;
    end
    task automatic raise(input int i);
        @(posedge ref_clk);
        tgl_out[i] <= ~tgl_out[i];
    endtask
endmodule

// ===== sim/scb_unit_bench.sv
// Directed bench for the sense condition branch unit: sequencer and APB tasks.
// Assumes scb_pkg, scb_map.svh and scb_partner are compiled first.
`timescale 1ns/100ps
`include "scb_map.svh"
`define SCB_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module scb_unit_bench import scb_pkg::*;;
    localparam int EXEC = 8;
    localparam logic [5:0] PCODE [4] = '{`SCB_AUX_MPAR, `SCB_AUX_APAR, `SCB_AUX_TPAR,
        `SCB_AUX_SPAR};
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, busy, branch_done, ovf_auto_branch, irq;
    logic branch_on_sense_start = 1'b0, operate_command_evt = 1'b0, right_ovf_evt = 1'b0;
    logic overflow_enable_bit = 1'b0, right_overflow_branch_bit = 1'b0;
    logic console_ovf_switch = 1'b0, switchover_done = 1'b0;
    logic [5:0] operate_aux = 6'h00;
    logic [4:0] evt = 5'h00;
    logic [3:0] sense_switch = 4'h0, p_tgl, n_tgl;
    logic [7:0] rx_cnt;
    logic [16:0] pc_in = 17'h00123, addr_in = 17'h1ABCD;
    scb_instr_s instr = '0;
    scb_branch_s branch_out;
    int error_cnt = 0, tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    scb_unit #(.EXEC_CYCLES(EXEC)) uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .branch_on_sense_start, .instr, .pc_in, .addr_in,
        .busy, .branch_done, .branch_out, .operate_command_evt, .operate_aux, .right_ovf_evt,
        .overflow_enable_bit, .right_overflow_branch_bit, .ovf_auto_branch,
        .mem_parity_evt(evt[0]), .adrum_parity_evt(evt[1]), .tape_parity_evt(evt[2]),
        .sdrum_parity_evt(evt[3]), .inactivity_evt(evt[4]), .console_ovf_switch,
        .sense_switch, .switchover_done, .partner_notify_tgl(p_tgl),
        .notify_partner_tgl(n_tgl), .irq);
    scb_partner partner (.ref_clk, .notify_in(n_tgl), .tgl_out(p_tgl), .rx_cnt);
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang();
        error_cnt++;
        $display("[ERR] handshake exp=1 got=0");
        print_verdict();
    endtask
    task automatic done_test(input string s);
        $display("test %s ended, mismatches %0d", s, error_cnt);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        if (!w) `SCB_CHK("prdata", exp, prdata)
        `SCB_CHK("pslverr", exp_err, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic branch_on_sense(input logic [5:0] aux, input logic exp);
        int n;
        // The accepting cycle is the first of the execution time.
        n = 1;
        @(posedge ref_clk);
        branch_on_sense_start <= 1'b1;
        instr <= '{opcode: `SCB_OP_BSN, aux: aux};
        @(posedge ref_clk);
        branch_on_sense_start <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (branch_done !== 1'b1 && n < 40);
        if (n >= 40) hang();
        `SCB_CHK("exec_cycles", EXEC, n)
        `SCB_CHK("taken", exp, branch_out.taken)
        `SCB_CHK("pc", exp ? addr_in : pc_in, branch_out.pc)
        `SCB_CHK("right_a", exp ? pc_in : 17'h00000, branch_out.right_a)
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk);
        evt[k] <= 1'b1;
        @(posedge ref_clk);
        evt[k] <= 1'b0;
    endtask
    task automatic ovf(input logic en, input logic br, input logic exp);
        @(posedge ref_clk);
        right_ovf_evt <= 1'b1;
        overflow_enable_bit <= en;
        right_overflow_branch_bit <= br;
        @(posedge ref_clk);
        right_ovf_evt <= 1'b0;
        #1;
        `SCB_CHK("auto_branch", exp, ovf_auto_branch)
        @(posedge ref_clk);
        #1;
        `SCB_CHK("auto_branch_end", 1'b0, ovf_auto_branch)
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        hang();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            branch_on_sense(PCODE[i], 1'b1);
            branch_on_sense(PCODE[i], 1'b0);
            branch_on_sense(i < 2 ? `SCB_AUX_AL1 : `SCB_AUX_AL2, 1'b1);
            branch_on_sense(i < 2 ? `SCB_AUX_AL1 : `SCB_AUX_AL2, 1'b0);
        end
        pulse(4);
        branch_on_sense(`SCB_AUX_MPAR, 1'b0);
        branch_on_sense(`SCB_AUX_AL1, 1'b1);
        done_test("parity_alarm");
        @(posedge ref_clk);
        console_ovf_switch <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ovf(1'b0, 1'b1, 1'b0);
        branch_on_sense(`SCB_AUX_ROVF, 1'b0);
        ovf(1'b1, 1'b0, 1'b0);
        branch_on_sense(`SCB_AUX_ROVF, 1'b1);
        branch_on_sense(`SCB_AUX_ROVF, 1'b0);
        ovf(1'b1, 1'b1, 1'b1);
        branch_on_sense(`SCB_AUX_ROVF, 1'b1);
        @(posedge ref_clk);
        console_ovf_switch <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ovf(1'b1, 1'b1, 1'b0);
        branch_on_sense(`SCB_AUX_ROVF, 1'b1);
        done_test("overflow");
        @(posedge ref_clk);
        sense_switch <= 4'b0101;
        repeat (4) @(posedge ref_clk);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) branch_on_sense(6'(`SCB_AUX_SW1 + i), sense_switch[i]);
        end
        apb(1'b0, `SCB_ADDR_INPUTS, 32'h0, 32'h0A, 1'b0);
        branch_on_sense(`SCB_AUX_SWO, 1'b0);
        @(posedge ref_clk);
        switchover_done <= 1'b1;
        repeat (4) @(posedge ref_clk);
        branch_on_sense(`SCB_AUX_SWO, 1'b1);
        branch_on_sense(`SCB_AUX_SWO, 1'b1);
        done_test("switches");
        for (int i = 0; i < 4; i++) partner.raise(i);
        repeat (5) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) branch_on_sense(6'(`SCB_AUX_IC1 + i), 1'b1);
        for (int i = 0; i < 4; i++) branch_on_sense(6'(`SCB_AUX_IC1 + i), 1'b0);
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            operate_command_evt <= 1'b1;
            operate_aux <= 6'(`SCB_OPR_IC1 + i);
            @(posedge ref_clk);
            operate_command_evt <= 1'b0;
            repeat (3) @(posedge ref_clk);
            `SCB_CHK("partner_rx", 8'(i < 4 ? i + 1 : 4), rx_cnt)
        end
        `SCB_CHK("notify", 4'hF, n_tgl)
        done_test("intercom");
        apb(1'b0, `SCB_ADDR_ISTAT, 32'h0, 32'h7FF, 1'b0);
        apb(1'b1, `SCB_ADDR_IMASK, 32'h2, 32'h0, 1'b0);
        pulse(2);
        repeat (2) @(posedge ref_clk);
        #1;
        `SCB_CHK("irq_masked", 1'b0, irq)
        pulse(0);
        repeat (2) @(posedge ref_clk);
        #1;
        `SCB_CHK("irq_raised", 1'b1, irq)
        apb(1'b0, `SCB_ADDR_ISTAT, 32'h0, 32'h6A, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        `SCB_CHK("irq_cleared", 1'b0, irq)
        branch_on_sense(6'h01, 1'b0);
        branch_on_sense(6'h0C, 1'b0);
        branch_on_sense(6'h3F, 1'b0);
        apb(1'b1, `SCB_ADDR_FLAGS, 32'h7FF, 32'h0, 1'b0);
        apb(1'b0, `SCB_ADDR_FLAGS, 32'h0, 32'h6A, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        @(posedge ref_clk);
        branch_on_sense_start <= 1'b1;
        instr <= '{opcode: 6'h2B, aux: `SCB_AUX_MPAR};
        @(posedge ref_clk);
        branch_on_sense_start <= 1'b0;
        #1;
        `SCB_CHK("busy_refused", 1'b0, busy)
        branch_on_sense(`SCB_AUX_MPAR, 1'b1);
        done_test("irq_unassigned");
        print_verdict();
    end
endmodule
